// *** rtl/aicf_top.sv ***
// Top: configuration word decode, conversion start detect and result formatting
// Overview of operation
// - Unipolar range results are presented as straight binary.
// - Bipolar range results are presented in twos complement.
// - Over-range saturates to 0xFFFF unipolar or 0x7FFF bipolar.
// - Under-range saturates to 0x0000 unipolar or 0x8000 bipolar.
// - Mode 111 selects single-ended inputs against ground.
// - Mode 010 selects bipolar inputs against common at half reference.
// - Mode 110 selects unipolar inputs against common as ground sense.
// - Mode 00X selects bipolar pairs, negative member at half reference.
// - Mode 10X selects unipolar pairs, negative member ground sense.
// - In pairs the channel field odd/even bit picks the positive pair member.
// - Sequencer in paired modes always uses even inputs as positive.
// - Filter bit selects full or quarter input bandwidth.
// - All settings but the sequencer_active input come from one 14-bit configuration word.
`timescale 1ns/1ps
module aicf_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic [13:0] cfg_word,
  input wire logic cfg_load,
  input wire logic sequencer_active,
  input wire logic conversion_start_pin,
  input wire logic raw_done,
  input wire logic [15:0] raw_code,
  input wire logic raw_over,
  input wire logic raw_under,
  output logic [2:0] pair_positive_input,
  output logic [2:0] pair_negative_input,
  output logic neg_is_com,
  output logic bipolar,
  output logic paired,
  output logic quarter_bw,
  output logic sample_hold,
  output logic [15:0] result,
  output logic result_valid
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [13:0] cfg;
    aicf_pkg::aicf_dec_t dec;
    aicf_pkg::aicf_dec_t conv_dec;
    logic start_d;
    logic hold;
  } aicf_state_t;

  aicf_state_t st;
  aicf_state_t next_st;
  aicf_pkg::aicf_dec_t dec_c;
  aicf_pkg::aicf_raw_t raw;
  logic [2:0] mode_f;
  logic [2:0] ch_f;

  // ---------------------------------------------------------------
  // Configuration decode
  // ---------------------------------------------------------------
  assign mode_f = st.cfg[aicf_pkg::MODE_HI:aicf_pkg::MODE_LO];
  assign ch_f = st.cfg[aicf_pkg::CH_HI:aicf_pkg::CH_LO];

  // Decode of the stored word; reserved code 011 falls back to single-ended
  always_comb begin
    dec_c = '0;
    dec_c.quarter_bw = st.cfg[aicf_pkg::FILT_BIT];
    dec_c.pos_ch = ch_f;
    dec_c.neg_ch = ch_f;
    if (mode_f == aicf_pkg::MODE_SINGLE) begin
      dec_c.mode = aicf_pkg::AICF_SINGLE;
    end else if (mode_f == aicf_pkg::MODE_COM_BIP) begin
      dec_c.mode = aicf_pkg::AICF_COM_BIP;
      dec_c.bipolar = 1'b1;
      dec_c.neg_is_com = 1'b1;
    end else if (mode_f == aicf_pkg::MODE_COM_UNI) begin
      dec_c.mode = aicf_pkg::AICF_COM_UNI;
      dec_c.neg_is_com = 1'b1;
    end else if (mode_f[2:1] == aicf_pkg::MODE_PAIR_BIP) begin
      dec_c.mode = aicf_pkg::AICF_PAIR_BIP;
      dec_c.bipolar = 1'b1;
      dec_c.paired = 1'b1;
    end else if (mode_f[2:1] == aicf_pkg::MODE_PAIR_UNI) begin
      dec_c.mode = aicf_pkg::AICF_PAIR_UNI;
      dec_c.paired = 1'b1;
    end else begin
      dec_c.mode = aicf_pkg::AICF_RSVD;
    end
    // Pair members: low bit chooses which of the adjacent pair is positive
    if (dec_c.paired) begin
      if (sequencer_active) begin
        dec_c.pos_ch = {ch_f[2:1], 1'b0};
      end else begin
        dec_c.pos_ch = ch_f;
      end
      dec_c.neg_ch = {dec_c.pos_ch[2:1], ~dec_c.pos_ch[0]};
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Settings are captured at the start edge so a mid-conversion write
  // cannot change the coding of the result being converted
  always_comb begin
    next_st = st;
    next_st.start_d = conversion_start_pin;
    if (cfg_load) begin
      next_st.cfg = cfg_word;
    end
    next_st.dec = dec_c;
    if (conversion_start_pin && !st.start_d) begin
      next_st.hold = 1'b1;
      next_st.conv_dec = dec_c;
    end else if (raw_done) begin
      next_st.hold = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= '{cfg: aicf_pkg::CFG_RESET, dec: '0, conv_dec: '0, start_d: 1'b0, hold: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Result formatting
  // ---------------------------------------------------------------
  assign raw = '{code: raw_code, over: raw_over, under: raw_under};

  aicf_format u_format (
    .clk(clk),
    .reset(reset),
    .load(raw_done),
    .bipolar(st.conv_dec.bipolar),
    .raw(raw),
    .code(result),
    .valid(result_valid)
  );

  // Outputs straight from registers
  assign pair_positive_input = st.dec.pos_ch;
  assign pair_negative_input = st.dec.neg_ch;
  assign neg_is_com = st.dec.neg_is_com;
  assign bipolar = st.dec.bipolar;
  assign paired = st.dec.paired;
  assign quarter_bw = st.dec.quarter_bw;
  assign sample_hold = st.hold;

  // ---------------------------------------------------------------
  // Decode checks
  // ---------------------------------------------------------------
  // Decoded outputs trail the stored word by one edge
  single_mode_a: assert property (@(posedge clk) disable iff (reset)
    mode_f == 3'h7 |=> !bipolar && !paired && !neg_is_com)
    else $error("single-ended decode wrong");
  com_bip_a: assert property (@(posedge clk) disable iff (reset)
    mode_f == 3'h2 |=> bipolar && neg_is_com && !paired)
    else $error("bipolar common decode wrong");
  com_uni_a: assert property (@(posedge clk) disable iff (reset)
    mode_f == 3'h6 |=> !bipolar && neg_is_com && !paired)
    else $error("unipolar common decode wrong");
  pair_bip_a: assert property (@(posedge clk) disable iff (reset)
    mode_f[2:1] == 2'h0 |=> bipolar && paired && !neg_is_com)
    else $error("bipolar pair decode wrong");
  pair_uni_a: assert property (@(posedge clk) disable iff (reset)
    mode_f[2:1] == 2'h2 |=> !bipolar && paired && !neg_is_com)
    else $error("unipolar pair decode wrong");
  rsvd_mode_a: assert property (@(posedge clk) disable iff (reset)
    mode_f == 3'h3 |=> !bipolar && !paired && !neg_is_com)
    else $error("reserved mode does not fall back to single-ended flags");
  pair_member_a: assert property (@(posedge clk) disable iff (reset)
    paired |-> pair_negative_input == (pair_positive_input ^ 3'h1))
    else $error("pair members not adjacent");
  pair_pos_a: assert property (@(posedge clk) disable iff (reset)
    dec_c.paired && !sequencer_active |=> pair_positive_input == $past(ch_f))
    else $error("positive pair member not taken from channel field");
  seq_even_a: assert property (@(posedge clk) disable iff (reset)
    dec_c.paired && sequencer_active |=> !pair_positive_input[0])
    else $error("sequencer positive channel not even");
  filter_sel_a: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> quarter_bw == $past(st.cfg[aicf_pkg::FILT_BIT]))
    else $error("filter select not following word");
  cfg_take_a: assert property (@(posedge clk) disable iff (reset)
    cfg_load |=> st.cfg == $past(cfg_word))
    else $error("configuration word not stored on load");

  // ---------------------------------------------------------------
  // Conversion checks
  // ---------------------------------------------------------------
  // A level-high start pin must not retrigger; only the 0 to 1 step counts,
  // and the coding seen at that step is the one the result is formatted with
  start_hold_a: assert property (@(posedge clk) disable iff (reset)
    $rose(conversion_start_pin) && !raw_done |=> sample_hold)
    else $error("start edge did not hold sample");
  hold_end_a: assert property (@(posedge clk) disable iff (reset)
    raw_done && !(conversion_start_pin && !st.start_d) |=> !sample_hold)
    else $error("hold not released at conversion end");
  coding_latch_a: assert property (@(posedge clk) disable iff (reset)
    conversion_start_pin && !st.start_d |=> st.conv_dec.bipolar == $past(dec_c.bipolar))
    else $error("coding not latched at start edge");
  result_pulse_a: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> result_valid == $past(raw_done))
    else $error("result valid pulse not one edge after done");
  sat_top_a: assert property (@(posedge clk) disable iff (reset)
    raw_done && raw_over |=> result == ($past(st.conv_dec.bipolar) ? 16'h7FFF : 16'hFFFF))
    else $error("over-range result not at top code");
  sat_bot_a: assert property (@(posedge clk) disable iff (reset)
    raw_done && !raw_over && raw_under |=> result == ($past(st.conv_dec.bipolar) ? 16'h8000 : 16'h0000))
    else $error("under-range result not at bottom code");

  // Main scenarios
  cfg_load_c: cover property (@(posedge clk) disable iff (reset) cfg_load ##1 $rose(conversion_start_pin));
  bip_res_c: cover property (@(posedge clk) disable iff (reset) result_valid && st.conv_dec.bipolar);
  sat_res_c: cover property (@(posedge clk) disable iff (reset) raw_done && raw_over);
  seq_pair_c: cover property (@(posedge clk) disable iff (reset) paired && sequencer_active);
  quarter_conv_c: cover property (@(posedge clk) disable iff (reset) quarter_bw && $rose(conversion_start_pin));

endmodule

// *** rtl/aicf_pkg.sv ***
// Package: configuration field layout, input modes and code constants for the input decode block
package aicf_pkg;

  localparam int CFG_W = 14;
  localparam int CODE_W = 16;
  localparam int CH_W = 3;
  localparam int CH_COUNT = 8;

  // Field positions inside the 14-bit configuration word
  localparam int MODE_HI = 12;
  localparam int MODE_LO = 10;
  localparam int CH_HI = 9;
  localparam int CH_LO = 7;
  localparam int FILT_BIT = 6;

  // Input mode field encodings
  localparam logic [2:0] MODE_SINGLE = 3'h7;
  localparam logic [2:0] MODE_COM_BIP = 3'h2;
  localparam logic [2:0] MODE_COM_UNI = 3'h6;
  localparam logic [1:0] MODE_PAIR_BIP = 2'h0;
  localparam logic [1:0] MODE_PAIR_UNI = 2'h2;

  // Saturation and reset codes
  localparam logic [15:0] CODE_TOP_UNI = 16'hFFFF;
  localparam logic [15:0] CODE_BOT_UNI = 16'h0000;
  localparam logic [15:0] CODE_TOP_BIP = 16'h7FFF;
  localparam logic [15:0] CODE_BOT_BIP = 16'h8000;
  localparam logic [15:0] CODE_RESET = 16'h0000;
  localparam logic [13:0] CFG_RESET = 14'h3FFF;
  localparam logic [15:0] MSB_FLIP = 16'h8000;

  typedef enum logic [2:0] {
    AICF_SINGLE = 3'b000,
    AICF_COM_BIP = 3'b001,
    AICF_COM_UNI = 3'b010,
    AICF_PAIR_BIP = 3'b011,
    AICF_PAIR_UNI = 3'b100,
    AICF_RSVD = 3'b101
  } aicf_mode_t;

  // Decoded configuration
  typedef struct packed {
    aicf_mode_t mode;
    logic bipolar;
    logic paired;
    logic [2:0] pos_ch;
    logic [2:0] neg_ch;
    logic neg_is_com;
    logic quarter_bw;
  } aicf_dec_t;

  // Raw conversion outcome from the analog core
  typedef struct packed {
    logic [15:0] code;
    logic over;
    logic under;
  } aicf_raw_t;

endpackage

// *** rtl/aicf_format.sv ***
// Code formatter: straight binary or twos complement with saturation, registered output
`timescale 1ns/1ps
module aicf_format (
  input wire logic clk,
  input wire logic reset,
  input wire logic load,
  input wire logic bipolar,
  input wire aicf_pkg::aicf_raw_t raw,
  output logic [15:0] code,
  output logic valid
);

  typedef struct packed {
    logic [15:0] code;
    logic valid;
  } aicf_fmt_state_t;

  aicf_fmt_state_t st;
  aicf_fmt_state_t next_st;

  // Over-range has priority over under-range; both cannot come from a real sample
  always_comb begin
    next_st = st;
    next_st.valid = load;
    if (load) begin
      if (raw.over) begin
        next_st.code = bipolar ? aicf_pkg::CODE_TOP_BIP : aicf_pkg::CODE_TOP_UNI;
      end else if (raw.under) begin
        next_st.code = bipolar ? aicf_pkg::CODE_BOT_BIP : aicf_pkg::CODE_BOT_UNI;
      end else if (bipolar) begin
        next_st.code = raw.code ^ aicf_pkg::MSB_FLIP;
      end else begin
        next_st.code = raw.code;
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= '{code: aicf_pkg::CODE_RESET, valid: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign code = st.code;
  assign valid = st.valid;

  // Coding from the previous edge, registered every cycle, so the checks can judge the registered result
  logic bipolar_d;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bipolar_d <= 1'b0;
    end else begin
      bipolar_d <= bipolar;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  over_uni_a: assert property (@(posedge clk) disable iff (reset)
    load && raw.over && !bipolar |=> code == 16'hFFFF)
    else $error("unipolar over-range not saturated high");
  over_bip_a: assert property (@(posedge clk) disable iff (reset)
    load && raw.over && bipolar |=> code == 16'h7FFF)
    else $error("bipolar over-range not saturated high");
  under_sat_a: assert property (@(posedge clk) disable iff (reset)
    load && !raw.over && raw.under |=> code == (bipolar_d ? 16'h8000 : 16'h0000))
    else $error("under-range not saturated low");
  bip_flip_a: assert property (@(posedge clk) disable iff (reset)
    load && bipolar && !raw.over && !raw.under |=> code == ($past(raw.code) ^ 16'h8000))
    else $error("bipolar code is not offset binary with msb flipped");
  uni_pass_a: assert property (@(posedge clk) disable iff (reset)
    load && !bipolar && !raw.over && !raw.under |=> code == $past(raw.code))
    else $error("unipolar code not straight binary");
  hold_code_a: assert property (@(posedge clk) disable iff (reset)
    !load |=> $stable(code))
    else $error("result changed without a load");

endmodule

// *** verification/aicf_host_model.sv ***
// Partner model: host writing the configuration word, raising the start pin, core returning results
`timescale 1ns/1ps
module aicf_host_model #(
  parameter int BASE_GAP = 2
) (
  input wire logic clk,
  output logic [13:0] cfg_word,
  output logic cfg_load,
  output logic conversion_start_pin,
  output logic raw_done,
  output logic [15:0] raw_code,
  output logic raw_over,
  output logic raw_under
);
  // Idle levels from time zero
  initial begin
    cfg_word = 14'h0000;
    cfg_load = 1'b0;
    conversion_start_pin = 1'b0;
    raw_done = 1'b0;
    raw_code = 16'h0000;
    raw_over = 1'b0;
    raw_under = 1'b0;
  end

  // One-cycle load pulse, word held through the sampling edge
  task automatic write_cfg(input logic [13:0] w);
    @(posedge clk);
    cfg_word <= w;
    cfg_load <= 1'b1;
    @(posedge clk);
    cfg_load <= 1'b0;
  endtask

  // Spacing four times longer with quarter bandwidth, then a rising start edge
  task automatic start_conv();
    repeat (cfg_word[aicf_pkg::FILT_BIT] ? 4 * BASE_GAP : BASE_GAP) @(posedge clk);
    conversion_start_pin <= 1'b1;
    @(posedge clk);
    @(posedge clk);
  endtask

  // Result lines carry junk outside the done pulse, so stale data cannot pass
  task automatic deliver(input logic [15:0] code, input logic ov, input logic un);
    @(posedge clk);
    raw_done <= 1'b1;
    raw_code <= code;
    raw_over <= ov;
    raw_under <= un;
    @(posedge clk);
    raw_done <= 1'b0;
    raw_code <= ~code;
    raw_over <= ~ov;
    raw_under <= ~un;
    conversion_start_pin <= 1'b0;
  endtask
endmodule

// *** verification/tb_adc_input_config_and_code_format.sv ***
// Testbench: input decode and result coding of the converter control block
`timescale 1ns/1ps
module tb_adc_input_config_and_code_format;
  logic clk;
  logic reset;
  logic sequencer_active;
  logic [13:0] cfg_word;
  logic cfg_load, conversion_start_pin, raw_done, raw_over, raw_under;
  logic [15:0] raw_code, result;
  logic [2:0] pos, neg;
  logic neg_is_com, bipolar, paired, quarter_bw, sample_hold, result_valid;
  int errors;
  int checks;
  // Mode table: field value, bipolar, paired; last entry is the reserved code
  logic [2:0] modes [8] = '{3'h7, 3'h2, 3'h6, 3'h0, 3'h1, 3'h4, 3'h5, 3'h3};
  logic [7:0] bip_t = 8'b00011010;
  logic [7:0] pair_t = 8'b01111000;
  // Raw cases: normal, midscale, over, under, both flags
  logic [15:0] raws [5] = '{16'h1234, 16'h8000, 16'h1234, 16'h1234, 16'h1234};
  logic [4:0] ov_t = 5'b10100;
  logic [4:0] un_t = 5'b11000;
  logic [15:0] uni_e [5] = '{16'h1234, 16'h8000, 16'hFFFF, 16'h0000, 16'hFFFF};
  logic [15:0] bip_e [5] = '{16'h9234, 16'h0000, 16'h7FFF, 16'h8000, 16'h7FFF};

  aicf_host_model u_host (.clk(clk), .cfg_word(cfg_word), .cfg_load(cfg_load),
    .conversion_start_pin(conversion_start_pin), .raw_done(raw_done), .raw_code(raw_code),
    .raw_over(raw_over), .raw_under(raw_under));
  aicf_top u_dut (.clk(clk), .reset(reset), .cfg_word(cfg_word), .cfg_load(cfg_load),
    .sequencer_active(sequencer_active), .conversion_start_pin(conversion_start_pin),
    .raw_done(raw_done), .raw_code(raw_code), .raw_over(raw_over), .raw_under(raw_under),
    .pair_positive_input(pos), .pair_negative_input(neg), .neg_is_com(neg_is_com),
    .bipolar(bipolar), .paired(paired), .quarter_bw(quarter_bw), .sample_hold(sample_hold),
    .result(result), .result_valid(result_valid));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Load a word and let the two-edge decode latency pass
  task automatic set_cfg(input logic [2:0] mode, input logic [2:0] ch, input logic filt);
    u_host.write_cfg({1'b0, mode, ch, filt, 6'h00});
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Full conversion; the result pulse is awaited under a bound, optionally with a word rewrite mid-way
  task automatic convert(input int k, input logic [15:0] exp, input bit swap);
    int n;
    u_host.start_conv();
    #1 check(16'(sample_hold), 16'h0001, "hold after start");
    if (swap) u_host.write_cfg(14'h1C00);
    u_host.deliver(raws[k], ov_t[k], un_t[k]);
    for (n = 0; n < 8; n++) begin
      #1;
      if (result_valid === 1'b1) break;
      @(posedge clk);
    end
    if (n == 8) begin
      errors++;
      summarize();
    end else begin
      check(result, exp, "result code");
      check(16'(sample_hold), 16'h0000, "hold released");
      @(posedge clk);
      #1 check(16'(result_valid), 16'h0000, "valid pulse ends");
    end
  endtask

  initial begin
    reset = 1'b1;
    sequencer_active = 1'b0;
    errors = 0;
    checks = 0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    #1 check({14'h0, result_valid, sample_hold}, 16'h0000, "reset flags");
    check(result, 16'h0000, "reset result");
    repeat (2) @(posedge clk);
    #1 check({quarter_bw, pos}, 16'h000F, "reset decode");
    // Every input mode, alternating channels and filter
    for (int i = 0; i < 8; i++) begin
      set_cfg(modes[i], 3'(i), i[0]);
      check({bipolar, paired}, {14'h0, bip_t[i], pair_t[i]}, "mode flags");
      check(16'(quarter_bw), 16'(i[0]), "filter bit");
      check(16'(pos), 16'(i), "positive input");
      if (pair_t[i]) check({neg_is_com, neg}, {12'h0, 1'b0, 3'(i) ^ 3'h1}, "pair negative");
      check(16'(neg_is_com), 16'(i == 1 || i == 2), "common negative");
    end
    // Sequencer forces the even member positive
    @(posedge clk) sequencer_active <= 1'b1;
    set_cfg(3'h4, 3'h5, 1'b0);
    check({pos, neg}, 16'h0025, "sequencer pair");
    @(posedge clk) sequencer_active <= 1'b0;
    // Unipolar then bipolar coding, incl. saturation, quarter bandwidth on the second pass
    for (int m = 0; m < 2; m++) begin
      set_cfg(m ? 3'h0 : 3'h7, 3'h0, m[0]);
      for (int k = 0; k < 5; k++) convert(k, m ? bip_e[k] : uni_e[k], 1'b0);
    end
    // Word turned single-ended between start and result: coding stays as latched at the start edge
    convert(0, bip_e[0], 1'b1);
    summarize();
  end
endmodule
